// file: logic/ara_pkg.sv
// Purpose: constants for the adc result accumulator block
// Assumes: byte-wide special function register port from the cpu core
// Notes: offsets are the cpu's register addresses
//
// Summary of operation
// - two-bit field selects filter settling mode
// - calibration codes 1 to 5 start calibration, field reads zero
// - eleven-bit decimation from low byte, high part
// - data rate is analog clock/64/decimation
// - writing zero control clears whole accumulator
// - bipolar polarity sign-extends incoming values
// - adc power down clears accumulator operation
// - cpu sum mode adds bytes on low write
// - cpu subtract mode subtracts on low write
// - operation field selects shift, sum, sum-shift
// - count field sets results summed; interrupt
// - reading low byte clears completion interrupt
// - accumulator mapped as four ascending bytes
// - polarity bit: zero bipolar, one unipolar
// - overrange flag set, cleared by writing zero
package ara_pkg;
  // ===========================================
  // register offsets
  localparam logic [7:0] ARA_OFF_CONV1 = 8'h00dd;
  localparam logic [7:0] ARA_OFF_DEC_LO = 8'h00de;
  localparam logic [7:0] ARA_OFF_DEC_HI = 8'h00df;
  localparam logic [7:0] ARA_OFF_CTRL = 8'h00e1;
  localparam logic [7:0] ARA_OFF_SUM0 = 8'h00e2;
  localparam logic [7:0] ARA_OFF_SUM1 = 8'h00e3;
  localparam logic [7:0] ARA_OFF_SUM2 = 8'h00e4;
  localparam logic [7:0] ARA_OFF_SUM3 = 8'h00e5;
  // ===========================================
  // reset values
  localparam logic [7:0] ARA_RST_DEC_LO = 8'h001b;
  localparam logic [2:0] ARA_RST_DEC_HI = 3'h6;
  localparam logic [7:0] ARA_RST_CTRL = 8'h0000;
  // ===========================================
  // field positions
  localparam int ARA_POS_OVR = 7;
  localparam int ARA_POS_POL = 6;
  localparam int ARA_POS_SETTLE = 4;
  localparam int ARA_POS_OP = 6;
  localparam int ARA_POS_CNT = 3;
  // modulator divide
  localparam int ARA_MOD_DIV = 64;
  // ===========================================
  typedef enum logic [1:0] {ARA_OP_CPU, ARA_OP_SUM, ARA_OP_SHIFT, ARA_OP_SUMSHF} ara_op_t;
  typedef enum logic [2:0] {ARA_CAL_NONE, ARA_CAL_SELF_OG, ARA_CAL_SELF_O, ARA_CAL_SELF_G,
                            ARA_CAL_SYS_O, ARA_CAL_SYS_G, ARA_CAL_RES6, ARA_CAL_RES7} ara_cal_t;
  // cpu sub-mode codes in the count field when operation is 00
  localparam logic [2:0] ARA_CNT_CPU_ADD = 3'h2;
  localparam logic [2:0] ARA_CNT_CPU_SUB = 3'h4;
endpackage

// file: logic/ara_top.sv
// Purpose: adc back-end controls and 32-bit summation/shift accumulator
// Assumes: cpu register port synchronous to sys_clk; adc result strobe on sys_clk
// Notes: one cycle per register access; accumulator ops take one cycle
`timescale 1ns/100ps
module ara_top #(
  parameter int RES_W = 24
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic adc_powerdown,
  input wire logic aclk_tick,
  input wire logic result_valid,
  input wire logic [RES_W-1:0] result_data,
  output logic [1:0] settle_select,
  output logic [2:0] calib_code,
  output logic calib_start,
  output logic [10:0] decim_ratio,
  output logic data_rate_tick,
  output logic result_polarity,
  output logic accum_irq
);
  // ===========================================
  // register decode
  logic wr_conv1, wr_declo, wr_dechi, wr_ctrl, wr_s0, wr_s1, wr_s2, wr_s3, rd_s0;
  assign wr_conv1 = reg_wr && reg_addr == ara_pkg::ARA_OFF_CONV1;
  assign wr_declo = reg_wr && reg_addr == ara_pkg::ARA_OFF_DEC_LO;
  assign wr_dechi = reg_wr && reg_addr == ara_pkg::ARA_OFF_DEC_HI;
  assign wr_ctrl = reg_wr && reg_addr == ara_pkg::ARA_OFF_CTRL;
  assign wr_s0 = reg_wr && reg_addr == ara_pkg::ARA_OFF_SUM0;
  assign wr_s1 = reg_wr && reg_addr == ara_pkg::ARA_OFF_SUM1;
  assign wr_s2 = reg_wr && reg_addr == ara_pkg::ARA_OFF_SUM2;
  assign wr_s3 = reg_wr && reg_addr == ara_pkg::ARA_OFF_SUM3;
  assign rd_s0 = reg_rd && reg_addr == ara_pkg::ARA_OFF_SUM0;

  logic [1:0] settle_q;
  logic pol_q;
  logic [7:0] declo_q;
  logic [2:0] dechi_q;
  logic [7:0] ctrl_q;
  logic [31:0] acc_q;
  logic [31:0] stage_q;
  logic ovr_q;
  logic irq_q;
  logic [8:0] cnt_q;
  logic cal_q;
  logic [2:0] cal_code_q;

  ara_pkg::ara_op_t op;
  logic [2:0] cnt_sel, shf;
  assign op = ara_pkg::ara_op_t'(ctrl_q[7:6]);
  assign cnt_sel = ctrl_q[5:3];
  assign shf = ctrl_q[2:0];

  // converter control: settle, polarity, calibration
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'h0;
      pol_q <= 1'b0;
      cal_q <= 1'b0;
      cal_code_q <= 3'h0;
    end else begin
      cal_q <= 1'b0;
      if (wr_conv1) begin
        settle_q <= reg_wdata[ara_pkg::ARA_POS_SETTLE +: 2];
        pol_q <= reg_wdata[ara_pkg::ARA_POS_POL];
        cal_code_q <= reg_wdata[2:0];
        cal_q <= reg_wdata[2:0] != 3'h0 && reg_wdata[2:1] != 2'h3;
      end
    end
  end
  assign settle_select = settle_q;
  assign calib_code = cal_code_q;
  assign calib_start = cal_q;
  assign result_polarity = pol_q;

  // decimation ratio registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      declo_q <= ara_pkg::ARA_RST_DEC_LO;
      dechi_q <= ara_pkg::ARA_RST_DEC_HI;
    end else begin
      if (wr_declo) declo_q <= reg_wdata;
      if (wr_dechi) dechi_q <= reg_wdata[2:0];
    end
  end
  assign decim_ratio = {dechi_q, declo_q};

  // output rate divider: aclk/64 then /decimation
  logic [5:0] mod_cnt_q;
  logic [10:0] dec_cnt_q;
  logic rate_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mod_cnt_q <= 6'h0;
      dec_cnt_q <= 11'h0;
      rate_q <= 1'b0;
    end else begin
      rate_q <= 1'b0;
      if (adc_powerdown) begin
        mod_cnt_q <= 6'h0;
        dec_cnt_q <= 11'h0;
      end else if (aclk_tick) begin
        mod_cnt_q <= mod_cnt_q + 6'h1;
        if (mod_cnt_q == 6'(ara_pkg::ARA_MOD_DIV - 1)) begin
          if (dec_cnt_q + 11'h1 >= decim_ratio) begin
            dec_cnt_q <= 11'h0;
            rate_q <= 1'b1;
          end else begin
            dec_cnt_q <= dec_cnt_q + 11'h1;
          end
        end
      end
    end
  end
  assign data_rate_tick = rate_q;

  // summation control register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ctrl_q <= ara_pkg::ARA_RST_CTRL;
    else if (wr_ctrl) ctrl_q <= reg_wdata;
  end

  // ===========================================
  // accumulator datapath
  logic [31:0] res_ext;
  logic [8:0] cnt_target;
  logic [3:0] shf_amt, wr_shf_amt;
  logic [31:0] shifted, cpu_shifted;
  assign res_ext = pol_q ? {{(32-RES_W){1'b0}}, result_data}
                         : {{(32-RES_W){result_data[RES_W-1]}}, result_data};
  assign cnt_target = 9'(9'h2 << cnt_sel);
  // shift distance is field plus one, 1 to 8, so it needs four bits
  assign shf_amt = {1'b0, shf} + 4'h1;
  assign wr_shf_amt = {1'b0, reg_wdata[2:0]} + 4'h1;
  logic sum_go, shift_go, cpu_add, cpu_sub;
  assign sum_go = result_valid && (op == ara_pkg::ARA_OP_SUM || op == ara_pkg::ARA_OP_SUMSHF)
                  && !adc_powerdown;
  assign shift_go = wr_ctrl && reg_wdata[7:6] == 2'h2;
  // cpu arithmetic modes: staged bytes leave the accumulator alone
  assign cpu_add = op == ara_pkg::ARA_OP_CPU && cnt_sel == ara_pkg::ARA_CNT_CPU_ADD;
  assign cpu_sub = op == ara_pkg::ARA_OP_CPU && cnt_sel == ara_pkg::ARA_CNT_CPU_SUB;

  // staging bytes written by the cpu; byte0 write triggers the operation
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) stage_q <= 32'h0000_0000;
    else begin
      if (wr_s0) stage_q[7:0] <= reg_wdata;
      if (wr_s1) stage_q[15:8] <= reg_wdata;
      if (wr_s2) stage_q[23:16] <= reg_wdata;
      if (wr_s3) stage_q[31:24] <= reg_wdata;
    end
  end
  logic [31:0] cpu_val;
  assign cpu_val = {stage_q[31:8], reg_wdata};

  // wide sums keep carry or borrow for the overrange flag
  logic [32:0] add_wide, sub_wide, res_wide;
  assign add_wide = {1'b0, acc_q} + {1'b0, cpu_val};
  assign sub_wide = {1'b0, acc_q} - {1'b0, cpu_val};
  assign res_wide = {1'b0, acc_q} + {1'b0, res_ext};
  // right shifts: logical when unipolar, arithmetic when bipolar
  assign shifted = pol_q ? res_wide[31:0] >> shf_amt : 32'($signed(res_wide[31:0]) >>> shf_amt);
  assign cpu_shifted = pol_q ? acc_q >> wr_shf_amt : 32'($signed(acc_q) >>> wr_shf_amt);
  // an adc result is taken only when no cpu access owns the accumulator
  logic acc_busy, sum_take;
  assign acc_busy = (wr_ctrl && reg_wdata == 8'h00) || shift_go || wr_s0 || wr_s1 || wr_s2 || wr_s3;
  assign sum_take = sum_go && !acc_busy;

  // accumulator update
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 32'h0000_0000;
      cnt_q <= 9'h0;
      ovr_q <= 1'b0;
    end else if (adc_powerdown) begin
      acc_q <= 32'h0000_0000;
      cnt_q <= 9'h0;
    end else begin
      if (wr_conv1 && !reg_wdata[ara_pkg::ARA_POS_OVR]) ovr_q <= 1'b0;
      if (wr_ctrl && reg_wdata == 8'h00) begin
        acc_q <= 32'h0000_0000;
        cnt_q <= 9'h0;
      end else if (shift_go) begin
        acc_q <= cpu_shifted;
      end else if (wr_s0 && cpu_add) begin
        acc_q <= add_wide[31:0];
        if (pol_q ? add_wide[32] : (acc_q[31] == cpu_val[31] && add_wide[31] != acc_q[31]))
          ovr_q <= 1'b1;
      end else if (wr_s0 && cpu_sub) begin
        acc_q <= sub_wide[31:0];
        if (pol_q ? sub_wide[32] : (acc_q[31] != cpu_val[31] && sub_wide[31] != acc_q[31]))
          ovr_q <= 1'b1;
      end else if (!cpu_add && !cpu_sub && (wr_s0 || wr_s1 || wr_s2 || wr_s3)) begin
        if (wr_s0) acc_q[7:0] <= reg_wdata;
        if (wr_s1) acc_q[15:8] <= reg_wdata;
        if (wr_s2) acc_q[23:16] <= reg_wdata;
        if (wr_s3) acc_q[31:24] <= reg_wdata;
      end else if (sum_take) begin
        if (cnt_q + 9'h1 == cnt_target) begin
          cnt_q <= 9'h0;
          if (op == ara_pkg::ARA_OP_SUMSHF) acc_q <= shifted;
          else acc_q <= res_wide[31:0];
        end else begin
          cnt_q <= cnt_q + 9'h1;
          acc_q <= res_wide[31:0];
        end
        if (pol_q ? res_wide[32] : (acc_q[31] == res_ext[31] && res_wide[31] != acc_q[31]))
          ovr_q <= 1'b1;
      end
    end
  end

  // completion interrupt: set wins over read-clear
  logic done_ev;
  assign done_ev = sum_take && cnt_q + 9'h1 == cnt_target;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) irq_q <= 1'b0;
    else if (adc_powerdown) irq_q <= 1'b0;
    else if (done_ev) irq_q <= 1'b1;
    else if (rd_s0) irq_q <= 1'b0;
  end
  assign accum_irq = irq_q;

  // read mux; calibration field reads 000b
  always_comb begin
    unique case (reg_addr)
      ara_pkg::ARA_OFF_CONV1: reg_rdata = {ovr_q, pol_q, settle_q, 1'b0, 3'h0};
      ara_pkg::ARA_OFF_DEC_LO: reg_rdata = declo_q;
      ara_pkg::ARA_OFF_DEC_HI: reg_rdata = {5'h00, dechi_q};
      ara_pkg::ARA_OFF_CTRL: reg_rdata = ctrl_q;
      ara_pkg::ARA_OFF_SUM0: reg_rdata = acc_q[7:0];
      ara_pkg::ARA_OFF_SUM1: reg_rdata = acc_q[15:8];
      ara_pkg::ARA_OFF_SUM2: reg_rdata = acc_q[23:16];
      ara_pkg::ARA_OFF_SUM3: reg_rdata = acc_q[31:24];
      default: reg_rdata = 8'h00;
    endcase
  end

  // ===========================================
  // checks
  property p_clear;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_ctrl && reg_wdata == 8'h00 && !adc_powerdown) |=> acc_q == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("zero control did not clear");
  property p_pd;
    @(posedge sys_clk) disable iff (!resetn) adc_powerdown |=> acc_q == 32'h0000_0000 && !accum_irq;
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown kept accumulator");
  property p_add;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_s0 && !adc_powerdown && ctrl_q == 8'h10) |=> acc_q == $past(acc_q) + $past(cpu_val);
  endproperty
  a_add: assert property (p_add) else $error("cpu add wrong");
  property p_sub;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_s0 && !adc_powerdown && ctrl_q == 8'h20) |=> acc_q == $past(acc_q) - $past(cpu_val);
  endproperty
  a_sub: assert property (p_sub) else $error("cpu subtract wrong");
  property p_irq;
    @(posedge sys_clk) disable iff (!resetn) done_ev |=> accum_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("completion not flagged");
  property p_irqclr;
    @(posedge sys_clk) disable iff (!resetn) (rd_s0 && !done_ev) |=> !accum_irq;
  endproperty
  a_irqclr: assert property (p_irqclr) else $error("read did not clear irq");
  property p_calrd;
    @(posedge sys_clk) disable iff (!resetn) reg_addr == ara_pkg::ARA_OFF_CONV1 |-> reg_rdata[2:0] == 3'h0;
  endproperty
  a_calrd: assert property (p_calrd) else $error("calibration field not zero");
  property p_cal;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_conv1 && reg_wdata[2:0] == 3'h1) |=> calib_start ##1 (!calib_start || $past(wr_conv1));
  endproperty
  a_cal: assert property (p_cal) else $error("calibration start missing");
  property p_ovr;
    @(posedge sys_clk) disable iff (!resetn) $rose(ovr_q) |-> ovr_q until (wr_conv1 && !reg_wdata[7]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange dropped");
  // byte map, count step, eight-bit shift and rate pulse
  property p_bytewr;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_s1 && !adc_powerdown && ctrl_q[7:6] != 2'h0) |=> acc_q[15:8] == $past(reg_wdata);
  endproperty
  a_bytewr: assert property (p_bytewr) else $error("byte one write misplaced");
  property p_count;
    @(posedge sys_clk) disable iff (!resetn) (sum_take && cnt_q + 9'h1 != cnt_target) |=> cnt_q == $past(cnt_q) + 9'h1;
  endproperty
  a_count: assert property (p_count) else $error("result not counted");
  property p_shf8;
    @(posedge sys_clk) disable iff (!resetn)
    (shift_go && pol_q && reg_wdata[2:0] == 3'h7 && !adc_powerdown) |=> acc_q == $past(acc_q) >> 8;
  endproperty
  a_shf8: assert property (p_shf8) else $error("eight bit shift wrong");
  property p_rate;
    @(posedge sys_clk) disable iff (!resetn) data_rate_tick |=> !data_rate_tick;
  endproperty
  a_rate: assert property (p_rate) else $error("rate pulse too long");
  c_sum: cover property (@(posedge sys_clk) disable iff (!resetn) done_ev);
  c_add: cover property (@(posedge sys_clk) disable iff (!resetn) wr_s0 && ctrl_q == 8'h10);
  c_rate: cover property (@(posedge sys_clk) disable iff (!resetn) data_rate_tick);
  c_shift: cover property (@(posedge sys_clk) disable iff (!resetn) shift_go);
  c_sumshf: cover property (@(posedge sys_clk) disable iff (!resetn) done_ev && op == ara_pkg::ARA_OP_SUMSHF);
endmodule

// file: testbench/ara_adc_model.sv
// Purpose: stand-in for the modulator and filter feeding conversion results
// Assumes: results and analog clock enables are aligned to sys_clk
// Notes: analog clock enable runs at half the system rate
`timescale 1ns/100ps
module ara_adc_model (
  input wire logic sys_clk,
  output logic aclk_tick,
  output logic result_valid,
  output logic [23:0] result_data
);
  // ==========================================
  // free-running analog clock enable
  initial begin
    aclk_tick = 1'b0;
    result_valid = 1'b0;
    result_data = 24'h00_0000;
  end
  always @(posedge sys_clk) begin
    aclk_tick <= ~aclk_tick;
  end
  // ==========================================
  // one result, one cycle strobe
  task automatic send(input logic [23:0] v);
    @(posedge sys_clk);
    result_valid <= 1'b1;
    result_data <= v;
    @(posedge sys_clk);
    result_valid <= 1'b0;
    result_data <= ~v; // stale data never left standing
  endtask
endmodule

// file: testbench/adc_result_accumulator_tb.sv
// Purpose: self-checking bench for the accumulator and adc controls
// Assumes: register accesses are one-cycle strobes on sys_clk
// Notes: expected sums are worked out by hand from the operands
`timescale 1ns/100ps
module adc_result_accumulator_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic adc_powerdown = 1'b0;
  logic aclk_tick;
  logic result_valid;
  logic [23:0] result_data;
  logic [7:0] reg_rdata;
  logic [1:0] settle_select;
  logic [2:0] calib_code;
  logic [10:0] decim_ratio;
  logic calib_start;
  logic data_rate_tick;
  logic result_polarity;
  logic accum_irq;
  int err_total = 0;
  int comparisons = 0;
  int starts = 0;
  // ==========================================
  // clock and calibration start counter
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (calib_start === 1'b1) starts <= starts + 1;
  end
  ara_adc_model i_adc (.sys_clk(sys_clk), .aclk_tick(aclk_tick), .result_valid(result_valid),
    .result_data(result_data));
  ara_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_powerdown(adc_powerdown),
    .aclk_tick(aclk_tick), .result_valid(result_valid), .result_data(result_data),
    .settle_select(settle_select), .calib_code(calib_code), .calib_start(calib_start),
    .decim_ratio(decim_ratio), .data_rate_tick(data_rate_tick), .result_polarity(result_polarity),
    .accum_irq(accum_irq));
  // ==========================================
  // shared access and compare tasks
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    v = reg_rdata;
    reg_rd <= 1'b0;
  endtask
  task automatic rd32(output logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      rd(8'he2 + 8'(k), v[8*k +: 8]);
    end
  endtask
  task automatic wait_for(input string what, ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 600) begin
        err_total++;
        $display("ERROR %s expected 1 seen %b", what, s);
        end_sim();
      end
    end
  endtask
  task automatic stage(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    wr(8'he3, b1);
    wr(8'he4, b2);
    wr(8'he5, b3);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [7:0] v;
    rd(8'hde, v); chk("decimation_low", 8'h1b, v);
    rd(8'hdf, v); chk("decimation_high", 8'h06, v);
    rd(8'he1, v); chk("accumulate_control", 8'h00, v);
    chk("decim_ratio", 11'h61b, decim_ratio);
    $display("test reset done");
  endtask
  task automatic t_conv;
    logic [7:0] v;
    int s0;
    for (int i = 0; i < 8; i++) begin
      s0 = starts;
      wr(8'hdd, {1'b0, i[0], i[1:0], 1'b0, i[2:0]});
      rd(8'hdd, v); chk("calib read", 3'h0, v[2:0]);
      chk("calib starts", (i >= 1 && i <= 5), starts - s0);
      chk("settle_select", i[1:0], settle_select);
      chk("calib_code", i[2:0], calib_code);
      chk("result_polarity", i[0], result_polarity);
    end
    $display("test conv done");
  endtask
  task automatic t_cpu;
    logic [31:0] v;
    logic [7:0] f;
    wr(8'hdd, 8'h40);
    wr(8'he1, 8'h00);
    wr(8'he1, 8'h10);
    stage(8'h12, 8'h34, 8'h56);
    wr(8'he2, 8'h78);
    rd32(v); chk("cpu add", 32'h5634_1278, v);
    wr(8'he1, 8'h20);
    stage(8'h00, 8'h00, 8'h00);
    wr(8'he2, 8'h78);
    rd32(v); chk("cpu sub", 32'h5634_1200, v);
    wr(8'he1, 8'h87);
    rd32(v); chk("shift by eight", 32'h0056_3412, v);
    wr(8'he1, 8'h00);
    rd32(v); chk("clear", 32'h0000_0000, v);
    wr(8'he1, 8'h10);
    stage(8'hff, 8'hff, 8'hff);
    wr(8'he2, 8'hff);
    stage(8'h00, 8'h00, 8'h00);
    wr(8'he2, 8'h01);
    rd(8'hdd, f); chk("overrange set", 1'b1, f[7]);
    wr(8'hdd, 8'h40);
    rd(8'hdd, f); chk("overrange cleared", 1'b0, f[7]);
    $display("test cpu done");
  endtask
  task automatic t_adc;
    logic [31:0] v;
    wr(8'he1, 8'h00);
    wr(8'he1, 8'hc9);
    for (int k = 1; k < 5; k++) i_adc.send(24'(k * 256));
    wait_for("accum_irq", accum_irq);
    rd32(v); chk("sum then shift", 32'h0000_0280, v);
    chk("irq cleared", 1'b0, accum_irq);
    wr(8'he1, 8'h83);
    rd32(v); chk("shift only", 32'h0000_0028, v);
    wr(8'hdd, 8'h00);
    wr(8'he1, 8'h00);
    wr(8'he1, 8'h40);
    i_adc.send(24'hff_ffff);
    i_adc.send(24'hff_ffff);
    wait_for("accum_irq", accum_irq);
    rd32(v); chk("sign extend", 32'hffff_fffe, v);
    $display("test adc done");
  endtask
  task automatic t_pd;
    logic [31:0] v;
    wr(8'he1, 8'h00);
    wr(8'he1, 8'h40);
    adc_powerdown <= 1'b1;
    i_adc.send(24'h00_0100);
    i_adc.send(24'h00_0100);
    repeat (4) @(negedge sys_clk);
    chk("irq in power down", 1'b0, accum_irq);
    rd32(v); chk("sum in power down", 32'h0000_0000, v);
    adc_powerdown <= 1'b0;
    $display("test powerdown done");
  endtask
  task automatic t_rate;
    int n;
    wr(8'hde, 8'h02);
    wr(8'hdf, 8'h00);
    @(negedge sys_clk);
    chk("decim_ratio", 11'h002, decim_ratio);
    wait_for("data_rate_tick", data_rate_tick);
    @(negedge sys_clk);
    n = 1;
    while (data_rate_tick !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rate period", 256, n);
    $display("test rate done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_conv();
    t_cpu();
    t_adc();
    t_pd();
    t_rate();
    end_sim();
  end
endmodule
